/* File: verilog/dspil_regs.svh */
// constants of the pipeline stall interlock
`ifndef DSPIL_REGS_SVH
`define DSPIL_REGS_SVH
`define DSPIL_REG_W 4
`define DSPIL_BANK_W 2
`define DSPIL_CNT_W 2
`define DSPIL_STALL_CC_MISS 2'h1
`define DSPIL_STALL_BANK 2'h1
`define DSPIL_STALL_CST_LD 2'h1
`define DSPIL_STALL_FP_FWD 2'h1
`define DSPIL_STALL_COND 2'h1
`define DSPIL_STALL_STAT 2'h1
`define DSPIL_STALL_DUAL_N2 2'h1
`define DSPIL_STALL_DUAL_N1 2'h2
`define DSPIL_STALL_FXM_FWD 2'h1
`define DSPIL_STALL_NONE 2'h0
`endif

/* File: verilog/dspil_pkg.sv */
// types of the pipeline stall interlock
`default_nettype none
`include "dspil_regs.svh"
package dspil_pkg;
  typedef logic [`DSPIL_REG_W-1:0] dspil_reg_t;
  typedef logic [`DSPIL_CNT_W-1:0] dspil_cnt_t;
  // decoded view of one issued instruction
  typedef struct packed {
    logic vld;
    logic fp_res;
    logic fx_mul;
    logic cond;
    logic cond_set;
    logic dual;
    logic stat_wr;
    logic cst;
    logic wr_a_vld;
    dspil_reg_t wr_a;
    logic wr_b_vld;
    dspil_reg_t wr_b;
  } dspil_hist_t;
  typedef enum logic [1:0] {
    DSPIL_RUN,
    DSPIL_HOLD
  } dspil_state_t;
endpackage : dspil_pkg
`default_nettype wire

/* File: verilog/dspil_hist_stage.sv */
// one stage of the issued instruction history
`timescale 1ns/1ns
`default_nettype none
module dspil_hist_stage
  import dspil_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic adv_i,
  input wire dspil_hist_t d_i,
  output dspil_hist_t q_o
);
  typedef struct packed {
    dspil_hist_t h;
  } dspil_hs_t;
  dspil_hs_t st_r;
  dspil_hs_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (adv_i) begin
      st_nxt.h = d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.h;
endmodule : dspil_hist_stage
`default_nettype wire

/* File: verilog/dspil_interlock.sv */
// hazard detection and stall insertion between decode and execution
`timescale 1ns/1ns
`default_nettype none
`include "dspil_regs.svh"
module dspil_interlock
  import dspil_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  // decoded instruction offered for issue
  input wire logic dec_vld_i,
  input wire logic dec_compute_i,
  input wire logic dec_fp_res_i,
  input wire logic dec_fx_alu_i,
  input wire logic dec_mul_i,
  input wire logic dec_fx_mul_i,
  input wire logic dec_dual_i,
  input wire logic dec_cond_i,
  input wire logic dec_cond_set_i,
  input wire logic dec_stat_wr_i,
  input wire logic dec_uses_carry_i,
  input wire logic dec_cst_i,
  input wire logic dec_load_i,
  input wire logic dec_rd_a_vld_i,
  input wire dspil_reg_t dec_rd_a_i,
  input wire logic dec_rd_b_vld_i,
  input wire dspil_reg_t dec_rd_b_i,
  input wire logic dec_wr_a_vld_i,
  input wire dspil_reg_t dec_wr_a_i,
  input wire logic dec_wr_b_vld_i,
  input wire dspil_reg_t dec_wr_b_i,
  // memory side of the instruction offered for issue
  input wire logic pm_data_rd_i,
  input wire logic cc_miss_i,
  input wire logic core_acc_i,
  input wire logic [`DSPIL_BANK_W-1:0] core_bank_i,
  input wire logic dma_acc_i,
  input wire logic [`DSPIL_BANK_W-1:0] dma_bank_i,
  // pipeline control
  output logic hold_o,
  output logic issue_o,
  output logic bubble_o,
  output logic [`DSPIL_CNT_W-1:0] stall_cnt_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dspil_state_t fsm;
    dspil_cnt_t left;
    logic hold;
    logic issue;
    logic bubble;
    dspil_cnt_t cnt;
  } dspil_st_t;
  dspil_st_t st_r;
  dspil_st_t st_nxt;

  dspil_hist_t h1;
  dspil_hist_t h2;
  dspil_hist_t cur;
  logic adv;
  logic rd_a_h1;
  logic rd_b_h1;
  logic rd_a_h2;
  logic rd_b_h2;
  logic dep_h1;
  logic dual_h1;
  logic dual_h2;
  dspil_cnt_t need;

  // ****************************************
  // history of issued instructions
  // ****************************************
  always_comb begin
    cur = '0;
    cur.vld = dec_vld_i;
    cur.fp_res = dec_fp_res_i;
    cur.fx_mul = dec_fx_mul_i;
    cur.cond = dec_cond_i;
    cur.cond_set = dec_cond_set_i;
    cur.dual = dec_dual_i;
    cur.stat_wr = dec_stat_wr_i;
    cur.cst = dec_cst_i;
    cur.wr_a_vld = dec_wr_a_vld_i;
    cur.wr_a = dec_wr_a_i;
    cur.wr_b_vld = dec_wr_b_vld_i;
    cur.wr_b = dec_wr_b_i;
  end

  // a bubble shifts in as an empty slot, so spacing counts real cycles
  assign adv = (st_nxt.fsm == DSPIL_RUN);

  dspil_hist_stage u_h1 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .adv_i(1'b1),
    .d_i(adv && dec_vld_i ? cur : '0),
    .q_o(h1)
  );

  dspil_hist_stage u_h2 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .adv_i(1'b1),
    .d_i(h1),
    .q_o(h2)
  );

  // ****************************************
  // hazard detection
  // ****************************************
  function automatic logic hits(input logic v, input dspil_reg_t r, input dspil_hist_t h);
    hits = v && h.vld && ((h.wr_a_vld && h.wr_a == r) || (h.wr_b_vld && h.wr_b == r));
  endfunction : hits

  always_comb begin
    rd_a_h1 = hits(dec_rd_a_vld_i, dec_rd_a_i, h1);
    rd_b_h1 = hits(dec_rd_b_vld_i, dec_rd_b_i, h1);
    rd_a_h2 = hits(dec_rd_a_vld_i, dec_rd_a_i, h2);
    rd_b_h2 = hits(dec_rd_b_vld_i, dec_rd_b_i, h2);
    dep_h1 = rd_a_h1 || rd_b_h1;
    // both multiplier operands come from the same dual compute
    dual_h1 = dec_mul_i && h1.dual && rd_a_h1 && rd_b_h1;
    dual_h2 = dec_mul_i && h2.dual && rd_a_h2 && rd_b_h2 && !dep_h1;
    need = `DSPIL_STALL_NONE;
    if (dec_vld_i) begin
      // history is matched on registers and flags; one unrelated spacer clears every history hazard except the dual ones
      if (dual_h1) begin
        need = `DSPIL_STALL_DUAL_N1;
      end else if (dual_h2) begin
        need = `DSPIL_STALL_DUAL_N2;
      end else if (dec_mul_i && h1.fx_mul && dep_h1) begin
        need = `DSPIL_STALL_FXM_FWD;
      end else if (dec_compute_i && h1.fp_res && dep_h1
                   && !(dec_fx_alu_i && h1.fx_mul == 1'b0 && !dec_mul_i
                        && !h1.cond && h1.wr_a_vld && !dec_fp_res_i)) begin
        need = `DSPIL_STALL_FP_FWD;
      end else if (dec_compute_i && dep_h1 && h1.cond && h2.vld && h2.cond_set) begin
        need = `DSPIL_STALL_COND;
      end else if (dec_uses_carry_i && h1.vld && h1.stat_wr) begin
        need = `DSPIL_STALL_STAT;
      end else if (dec_load_i && h1.vld && h1.cst) begin
        need = `DSPIL_STALL_CST_LD;
      end else if (pm_data_rd_i && cc_miss_i) begin
        need = `DSPIL_STALL_CC_MISS;
      end else if (core_acc_i && dma_acc_i && core_bank_i == dma_bank_i) begin
        need = `DSPIL_STALL_BANK;
      end
    end
  end

  // ****************************************
  // stall sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.issue = 1'b0;
    st_nxt.bubble = 1'b0;
    unique case (st_r.fsm)
      DSPIL_RUN: begin
        if (need != `DSPIL_STALL_NONE) begin
          // the consumer waits; older work in execute keeps flowing
          st_nxt.fsm = DSPIL_HOLD;
          st_nxt.left = need - 2'h1;
          st_nxt.hold = 1'b1;
          st_nxt.bubble = 1'b1;
          st_nxt.cnt = need;
        end else begin
          st_nxt.hold = 1'b0;
          st_nxt.issue = dec_vld_i;
          st_nxt.cnt = `DSPIL_STALL_NONE;
        end
      end
      DSPIL_HOLD: begin
        if (st_r.left == 2'h0) begin
          // issue without re-checking: the producer has moved on
          st_nxt.fsm = DSPIL_RUN;
          st_nxt.hold = 1'b0;
          st_nxt.issue = dec_vld_i;
          // the count only stands while the consumer is held
          st_nxt.cnt = `DSPIL_STALL_NONE;
        end else begin
          st_nxt.left = st_r.left - 2'h1;
          st_nxt.bubble = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '{fsm: DSPIL_RUN, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hold_o = st_r.hold;
  assign issue_o = st_r.issue;
  assign bubble_o = st_r.bubble;
  assign stall_cnt_o = st_r.cnt;
endmodule : dspil_interlock
`default_nettype wire

/* File: sim/dspil_interlock_props.sv */
// assertions on the stall interlock outputs
`timescale 1ns/1ns
`default_nettype none
`include "dspil_regs.svh"
module dspil_interlock_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic dec_vld_i,
  input wire logic pm_data_rd_i,
  input wire logic cc_miss_i,
  input wire logic core_acc_i,
  input wire logic [`DSPIL_BANK_W-1:0] core_bank_i,
  input wire logic dma_acc_i,
  input wire logic [`DSPIL_BANK_W-1:0] dma_bank_i,
  input wire logic hold_o,
  input wire logic issue_o,
  input wire logic bubble_o,
  input wire logic [`DSPIL_CNT_W-1:0] stall_cnt_o
);
  // ****
  // stall timing
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // an offer only counts while the pipe is not holding
  wire take = dec_vld_i && !hold_o;
  property p_miss; take && pm_data_rd_i && cc_miss_i |=> hold_o && stall_cnt_o != 2'h0; endproperty
  a_miss: assert property (p_miss) else $error("miss not stalled");
  property p_bank;
    take && core_acc_i && dma_acc_i && core_bank_i == dma_bank_i |=> hold_o;
  endproperty
  a_bank: assert property (p_bank) else $error("bank clash not stalled");
  property p_one; $rose(hold_o) && stall_cnt_o == 2'h1 |=> !hold_o && issue_o; endproperty
  a_one: assert property (p_one) else $error("single stall length");
  property p_two;
    $rose(hold_o) && stall_cnt_o == 2'h2 |=> hold_o && bubble_o ##1 !hold_o && issue_o;
  endproperty
  a_two: assert property (p_two) else $error("double stall length");
  property p_ans; take |=> issue_o != hold_o; endproperty
  a_ans: assert property (p_ans) else $error("offer not answered");
  property p_idle; !dec_vld_i && !hold_o |=> !issue_o && !hold_o; endproperty
  a_idle: assert property (p_idle) else $error("issue without offer");
  property p_free; !hold_o |-> stall_cnt_o == 2'h0 && !bubble_o; endproperty
  a_free: assert property (p_free) else $error("bubble outside hold");
  property p_keep; hold_o && $past(hold_o) |-> $stable(stall_cnt_o); endproperty
  a_keep: assert property (p_keep) else $error("count moved in hold");
endmodule : dspil_interlock_props
bind dspil_interlock dspil_interlock_props u_props (.clk_i, .srst_i, .dec_vld_i, .pm_data_rd_i,
  .cc_miss_i, .core_acc_i, .core_bank_i, .dma_acc_i, .dma_bank_i, .hold_o, .issue_o, .bubble_o,
  .stall_cnt_o);
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the stall interlock
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin err_count++; \
  $display("[ERR] %s exp %0d got %0d", nm, e, s); end end
module testbench;
  logic clk, srst, vld, hold, iss, bub;
  logic [19:0] k;
  logic [7:0] x;
  logic [1:0] cb, db, ca, da, cnt;
  int err_count, tests_run, nb, e, q[$];
  dspil_interlock dut (
    .clk_i(clk), .srst_i(srst), .dec_vld_i(vld), .dec_compute_i(k[0]), .dec_fp_res_i(k[1]),
    .dec_fx_alu_i(k[2]), .dec_mul_i(k[3]), .dec_fx_mul_i(k[4]), .dec_dual_i(k[5]),
    .dec_cond_i(k[6]), .dec_cond_set_i(k[7]), .dec_stat_wr_i(k[8]), .dec_uses_carry_i(k[9]),
    .dec_cst_i(k[10]), .dec_load_i(k[11]), .pm_data_rd_i(k[12]), .cc_miss_i(k[13]),
    .core_acc_i(k[14]), .dma_acc_i(k[15]), .dec_rd_a_vld_i(k[16]), .dec_rd_b_vld_i(k[17]),
    .dec_wr_a_vld_i(k[18]), .dec_wr_b_vld_i(k[19]), .dec_rd_a_i(x[7:4]), .dec_rd_b_i(x[3:0]),
    .dec_wr_a_i(x[7:4]), .dec_wr_b_i(x[3:0]), .core_bank_i(cb), .dma_bank_i(db),
    .hold_o(hold), .issue_o(iss), .bubble_o(bub), .stall_cnt_o(cnt)
  );
  // ****
  // drivers and checks
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task final_report;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // hold rises a cycle after the offer, so inputs stand through offer and every stall edge
  task op(input logic [19:0] kk, input logic [7:0] xx, input int n);
    vld <= 1'b1;
    k <= kk;
    x <= xx;
    cb <= ca;
    db <= da;
    q.push_back(n);
    repeat (n + 1) @(posedge clk);
    `CHK("hold", n > 0, hold)
  endtask : op
  // two empty slots flush the two-deep history
  task gap;
    op(20'h0, 8'h0, 0);
    op(20'h0, 8'h0, 0);
  endtask : gap
  always @(posedge clk) begin
    if (!srst) begin
      if (bub === 1'b1 && nb == 0) `CHK("stall_cnt", q[0], cnt)
      if (bub === 1'b1) nb++;
      if (iss === 1'b1) begin
        e = (q.size() > 0) ? q.pop_front() : -1;
        `CHK("stalls", e, nb)
        nb = 0;
      end
    end
  end
  initial begin
    srst = 1'b1; vld = 1'b0; k = 20'h0; x = 8'h0; cb = 2'h0; db = 2'h0; ca = 2'h0; da = 2'h0;
    void'($urandom(15));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    op(20'h03000, 8'h00, 1);
    op(20'h01000, 8'h00, 0);
    op(20'h00400, 8'h00, 0);
    op(20'h00800, 8'h00, 1);
    op(20'h00400, 8'h00, 0);
    op(20'h0, 8'h0, 0);
    op(20'h00800, 8'h00, 0);
    op(20'h40003, 8'h10, 0);
    op(20'h10001, 8'h10, 1);
    op(20'h40003, 8'h10, 0);
    gap;
    op(20'h10001, 8'h10, 0);
    op(20'h00081, 8'h00, 0);
    op(20'h40041, 8'h20, 0);
    op(20'h10001, 8'h20, 1);
    op(20'h00100, 8'h00, 0);
    op(20'h00201, 8'h00, 1);
    op(20'hc0021, 8'h45, 0);
    op(20'h30009, 8'h45, 2);
    gap;
    op(20'hc0021, 8'h45, 0);
    op(20'h0, 8'h0, 0);
    op(20'h30009, 8'h45, 1);
    gap;
    op(20'h4000b, 8'h60, 0);
    op(20'h10005, 8'h60, 0);
    op(20'h40019, 8'h70, 0);
    op(20'h10009, 8'h70, 1);
    gap;
    for (int i = 0; i < 8; i++) begin
      ca = 2'($urandom);
      da = i[0] ? ca : ~ca;
      op(20'h0c000, 8'h00, i % 2);
    end
    vld <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("pending", 0, q.size())
    final_report();
  end
  initial begin
    repeat (1000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
